// *** sim/board_wiring.sv ***
// board model of the three lane select pins
// assumes pull-up enable from the selector; the board may leave a pin open
`timescale 1ns/1ps
module board_wiring (
  input wire logic clk,
  input wire logic [2:0] pullup_en,
  input wire logic [2:0] drive_en,
  input wire logic [2:0] drive_val,
  output logic [2:0] pin
);
  logic [2:0] last_r = 3'h0;
  always_ff @(posedge clk) begin
    last_r <= pin;
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // open pin without pull-up floats: toggle so a stale level never passes
      pin[i] = drive_en[i] ? drive_val[i] : (pullup_en[i] ? 1'b1 : ~last_r[i]);
    end
  end
endmodule : board_wiring

// *** sim/tb_combo_lane_select.sv ***
// self-checking bench for the combo lane selector
// assumes board_wiring model drives the select pins
`timescale 1ns/1ps
module tb_combo_lane_select;
  import combo_lane_pkg::*;
  logic clk = 0, rst_n = 0, lamp_sel = 0, act = 0;
  logic [5:0] flex = 6'h00;
  logic [2:0] pol = 3'h0, den = 3'h7, dval = 3'h0, pin, pu, nat, sata, pcie, s_o, s_oe, ilk;
  logic [2:0] sleep_sel = 3'h0, ilk_sel = 3'h0, dslp = 3'h0, ilk_in = 3'h0;
  logic done, l_o, l_oe;
  int n_fail = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  board_wiring bw (.clk(clk), .pullup_en(pu), .drive_en(den), .drive_val(dval), .pin(pin));
  combo_lane_select uut (.CORE_CLK(clk), .RESET_N(rst_n), .COMBO_PORT_FLEX_STRAP(flex),
    .COMBO_POLARITY_STRAP(pol), .LANE_TYPE_SELECT_PIN(pin), .LANE_SELECT_PULLUP_EN(pu),
    .LANE_SELECT_NATIVE(nat), .LANE_ROUTE_SATA(sata), .LANE_ROUTE_PCIE(pcie), .LANE_ASSIGN_DONE(done),
    .LAMP_NATIVE_SEL(lamp_sel), .SLEEP_NATIVE_SEL(sleep_sel), .INTERLOCK_NATIVE_SEL(ilk_sel),
    .SATA_ACTIVITY(act), .SATA_DEVICE_SLEEP(dslp), .ACTIVITY_LAMP_OUT_O(l_o), .ACTIVITY_LAMP_OUT_OE(l_oe),
    .DEVICE_SLEEP_OUT_O(s_o), .DEVICE_SLEEP_OUT_OE(s_oe), .INTERLOCK_SWITCH_INPUT(ilk_in),
    .INTERLOCK_TO_SATA(ilk));

  task chk(input logic [2:0] got, input logic [2:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // expected sata routing for all ports, pin level as the board presents it
  function automatic logic [2:0] exp_sata(input logic [5:0] f, input logic [2:0] p, input logic [2:0] lv);
    for (int i = 0; i < 3; i++) begin
      exp_sata[i] = (f[2*i+:2] == 2'h3) ? (lv[i] ^ p[i]) : (f[2*i+:2] == 2'h1);
    end
  endfunction : exp_sata

  function automatic logic [2:0] exp_pu(input logic [5:0] f);
    for (int i = 0; i < 3; i++) begin
      exp_pu[i] = f[2*i+:2] == 2'h3;
    end
  endfunction : exp_pu

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task run_case(input logic [5:0] f, input logic [2:0] p, input logic [2:0] e, input logic [2:0] v);
    logic [2:0] lv, want;
    int k;
    @(posedge clk);
    rst_n <= 1'b0;
    flex <= f;
    pol <= p;
    den <= e;
    dval <= v;
    repeat (2) @(posedge clk);
    #1;
    chk(l_oe, 1'b0, "lamp oe in reset");
    chk(s_oe, 3'h0, "sleep oe in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    lv = (e & v) | (~e & exp_pu(f));
    want = exp_sata(f, p, lv);
    for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
    if (k == 40) begin
      n_fail++;
      $display("[ERR] %0t assignment never completed", $time);
      final_report();
    end
    #1;
    chk(sata, want, "route sata");
    chk(pcie, ~want, "route pcie");
    chk(pu, exp_pu(f), "pull-up enable");
    chk(nat, 3'h7, "select pins native");
    chk(ilk, 3'h7, "interlock reads open");
    @(posedge clk);
    den <= 3'h7;
    dval <= ~lv;
    pol <= ~p;
    repeat (4) @(posedge clk);
    #1;
    chk(sata, want, "route held");
    $display("case flex %h pol %h done", f, p);
  endtask : run_case

  initial begin
    void'($urandom(32'h819e));
    run_case(6'h3f, 3'h0, 3'h0, 3'h0);
    run_case(6'h3f, 3'h0, 3'h7, 3'h5);
    run_case(6'h3f, 3'h7, 3'h7, 3'h5);
    run_case(6'h15, 3'h2, 3'h7, 3'h0);
    run_case(6'h28, 3'h5, 3'h7, 3'h7);
    repeat (12) run_case(6'($urandom), 3'($urandom), 3'($urandom), 3'($urandom));
    // port 0 pcie, ports 1 and 2 sata, so the interlock gating shows
    run_case(6'h14, 3'h0, 3'h7, 3'h0);
    @(posedge clk);
    act <= 1'b1;
    dslp <= 3'($urandom);
    ilk_in <= 3'($urandom);
    repeat (3) @(posedge clk);
    #1;
    chk(l_oe, 1'b0, "lamp undriven when not native");
    chk(s_oe, 3'h0, "sleep undriven when not native");
    chk(s_o, 3'h0, "sleep low when not native");
    chk(ilk, 3'h7, "interlock open when not native");
    @(posedge clk);
    lamp_sel <= 1'b1;
    sleep_sel <= 3'h7;
    ilk_sel <= 3'h7;
    repeat (3) @(posedge clk);
    #1;
    chk(l_oe, 1'b1, "lamp driven when native");
    chk(l_o, 1'b0, "lamp only pulls low");
    chk(s_oe, 3'h7, "sleep driven when native");
    chk(s_o, dslp, "sleep follows controller");
    chk(ilk, ilk_in | ~exp_sata(6'h14, 3'h0, 3'h0), "interlock on sata lanes only");
    $display("sideband test done");
    final_report();
  end
endmodule : tb_combo_lane_select

// *** verilog/combo_lane_decode.sv ***
// per-port decode of flex strap, polarity strap and sampled pin level
// assumes flex and polarity already held in registers by the caller; pin level arrives unregistered
`timescale 1ns/1ps
module combo_lane_decode
  import combo_lane_pkg::*;
(
  input wire logic [FLEX_W-1:0] flex,
  input wire logic polarity,
  input wire logic pin_level,
  output logic route_sata
);
  always_comb begin
    if (is_pin_select(flex)) begin
      // polarity 0: high means sata; polarity 1 inverts
      route_sata = pin_level ^ polarity;
    end else begin
      // anything but the forced-sata code falls back to pcie
      route_sata = (flex == FLEX_FORCE_SATA);
    end
  end
endmodule : combo_lane_decode

// *** verilog/combo_lane_pkg.sv ***
// constants and decode helpers for the combo lane selector
// assumes a single 200 MHz core clock and straps stable across reset
package combo_lane_pkg;
  localparam int NUM_PORTS = 3;
  localparam int FLEX_W = 2;
  localparam logic [1:0] FLEX_PIN_SELECT = 2'h3;
  localparam logic [1:0] FLEX_FORCE_SATA = 2'h1;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_TIME_NS = 100;
  // least time, so round up to whole cycles
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [2:0] PULLUP_RESET = 3'h7;
  localparam logic [2:0] LANE_NATIVE_RESET = 3'h7;
  localparam logic [2:0] ALL_CLEAR = 3'h0;
  localparam logic [2:0] INTERLOCK_OPEN = 3'h7;
  localparam logic [5:0] FLEX_CLEAR = 6'h00;

  function automatic logic is_pin_select(input logic [FLEX_W-1:0] flex);
    return flex == FLEX_PIN_SELECT;
  endfunction : is_pin_select
endpackage : combo_lane_pkg

// *** verilog/combo_lane_select.sv ***
// combo lane sata/pcie selector with sideband pad mode defaults
// assumes straps and pins synchronous to CORE_CLK, no register bus
`timescale 1ns/1ps

// Summary of operation
// - select pin decides sata or pcie only when flex strap is 11b
// - flex strap 11b enables the select pin's internal pull-up
// - polarity 0: pin low gives pcie, pin high gives sata
// - polarity 1: pin low gives sata, pin high gives pcie
// - lane select pins default to native function
// - lamp, sleep and interlock pins default to general purpose, undriven
// - without pin-based choice or other setting the lane goes to pcie
module combo_lane_select
  import combo_lane_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [NUM_PORTS*FLEX_W-1:0] COMBO_PORT_FLEX_STRAP,
  input wire logic [NUM_PORTS-1:0] COMBO_POLARITY_STRAP,
  input wire logic [NUM_PORTS-1:0] LANE_TYPE_SELECT_PIN,
  output logic [NUM_PORTS-1:0] LANE_SELECT_PULLUP_EN,
  output logic [NUM_PORTS-1:0] LANE_SELECT_NATIVE,
  output logic [NUM_PORTS-1:0] LANE_ROUTE_SATA,
  output logic [NUM_PORTS-1:0] LANE_ROUTE_PCIE,
  output logic LANE_ASSIGN_DONE,
  input wire logic LAMP_NATIVE_SEL,
  input wire logic [NUM_PORTS-1:0] SLEEP_NATIVE_SEL,
  input wire logic [NUM_PORTS-1:0] INTERLOCK_NATIVE_SEL,
  input wire logic SATA_ACTIVITY,
  input wire logic [NUM_PORTS-1:0] SATA_DEVICE_SLEEP,
  output logic ACTIVITY_LAMP_OUT_O,
  output logic ACTIVITY_LAMP_OUT_OE,
  output logic [NUM_PORTS-1:0] DEVICE_SLEEP_OUT_O,
  output logic [NUM_PORTS-1:0] DEVICE_SLEEP_OUT_OE,
  input wire logic [NUM_PORTS-1:0] INTERLOCK_SWITCH_INPUT,
  output logic [NUM_PORTS-1:0] INTERLOCK_TO_SATA
);
  typedef enum logic [1:0] {ST_STRAP, ST_SETTLE, ST_SAMPLE, ST_HOLD} seq_state_t;

  seq_state_t state_r;
  logic [CNT_W-1:0] settle_cnt_r;
  logic [NUM_PORTS*FLEX_W-1:0] flex_r;
  logic [NUM_PORTS-1:0] pol_r;
  logic [NUM_PORTS-1:0] pullup_r;
  logic [NUM_PORTS-1:0] route_sata_r;
  logic [NUM_PORTS-1:0] route_sata_nxt;
  logic [NUM_PORTS-1:0] pin_choice;
  logic lamp_native_r;
  logic [NUM_PORTS-1:0] sleep_native_r;
  logic [NUM_PORTS-1:0] interlock_native_r;
  logic lamp_oe_r;
  logic [NUM_PORTS-1:0] sleep_o_r;
  logic [NUM_PORTS-1:0] sleep_oe_r;
  logic [NUM_PORTS-1:0] interlock_r;

  // sampling sequence: straps first, then let the pull-up settle, then the pin
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_STRAP;
      settle_cnt_r <= CNT_ZERO;
    end else begin
      unique case (state_r)
        ST_STRAP: begin
          state_r <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (settle_cnt_r == SETTLE_LAST) begin
            state_r <= ST_SAMPLE;
          end
          settle_cnt_r <= settle_cnt_r + 5'h01;
        end
        ST_SAMPLE: begin
          state_r <= ST_HOLD;
        end
        ST_HOLD: begin
          state_r <= ST_HOLD;
        end
      endcase
    end
  end

  // straps are caught by the clock after release, never by the reset itself
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flex_r <= FLEX_CLEAR;
      pol_r <= ALL_CLEAR;
    end else if (state_r == ST_STRAP) begin
      flex_r <= COMBO_PORT_FLEX_STRAP;
      pol_r <= COMBO_POLARITY_STRAP;
    end
  end

  // pull-up on during reset so an open pin never floats
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pullup_r <= PULLUP_RESET;
    end else if (state_r == ST_STRAP) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        pullup_r[i] <= is_pin_select(COMBO_PORT_FLEX_STRAP[i*FLEX_W +: FLEX_W]);
      end
    end
  end

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    combo_lane_decode u_decode (
      .flex(flex_r[g*FLEX_W +: FLEX_W]),
      .polarity(pol_r[g]),
      .pin_level(LANE_TYPE_SELECT_PIN[g]),
      .route_sata(route_sata_nxt[g])
    );
    assign pin_choice[g] = is_pin_select(flex_r[g*FLEX_W +: FLEX_W]);
  end

  // pcie until sampled; the single capture is then frozen
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      route_sata_r <= ALL_CLEAR;
    end else if (state_r == ST_SAMPLE) begin
      route_sata_r <= route_sata_nxt;
    end
  end

  // software picks native function for sideband pads; default is gp
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lamp_native_r <= 1'b0;
      sleep_native_r <= ALL_CLEAR;
      interlock_native_r <= ALL_CLEAR;
    end else begin
      lamp_native_r <= LAMP_NATIVE_SEL;
      sleep_native_r <= SLEEP_NATIVE_SEL;
      interlock_native_r <= INTERLOCK_NATIVE_SEL;
    end
  end

  // pads stay undriven until their native mode is in effect
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lamp_oe_r <= 1'b0;
      sleep_o_r <= ALL_CLEAR;
      sleep_oe_r <= ALL_CLEAR;
    end else begin
      lamp_oe_r <= lamp_native_r & SATA_ACTIVITY;
      sleep_o_r <= sleep_native_r & SATA_DEVICE_SLEEP;
      sleep_oe_r <= sleep_native_r;
    end
  end

  // interlock reads open unless the pad is native and the lane is sata
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      interlock_r <= INTERLOCK_OPEN;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        interlock_r[i] <= (interlock_native_r[i] & route_sata_r[i]) ? INTERLOCK_SWITCH_INPUT[i] : 1'b1;
      end
    end
  end

  assign LANE_SELECT_PULLUP_EN = pullup_r;
  // selection pins never leave native use in this block
  assign LANE_SELECT_NATIVE = LANE_NATIVE_RESET;
  assign LANE_ROUTE_SATA = route_sata_r;
  assign LANE_ROUTE_PCIE = ~route_sata_r;
  assign LANE_ASSIGN_DONE = (state_r == ST_HOLD);
  // open drain: only ever pulls low
  assign ACTIVITY_LAMP_OUT_O = 1'b0;
  assign ACTIVITY_LAMP_OUT_OE = lamp_oe_r;
  assign DEVICE_SLEEP_OUT_O = sleep_o_r;
  assign DEVICE_SLEEP_OUT_OE = sleep_oe_r;
  assign INTERLOCK_TO_SATA = interlock_r;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_sample_step;
    state_r == ST_SAMPLE;
  endsequence

  sequence s_hold_forever;
    state_r == ST_HOLD [*8];
  endsequence

  a_route_frozen: assert property (state_r == ST_HOLD |=> $stable(route_sata_r))
    else $error("lane assignment changed after sampling");
  a_sample_once: assert property (s_sample_step |=> s_hold_forever)
    else $error("sample step repeated");
  a_done_bound: assert property ($rose(RESET_N) |-> ##[1:30] LANE_ASSIGN_DONE)
    else $error("assignment not done in time");
  a_pin_polarity: assert property (s_sample_step and pin_choice[0]
      |=> LANE_ROUTE_SATA[0] == ($past(LANE_TYPE_SELECT_PIN[0]) ^ pol_r[0]))
    else $error("pin polarity mapping wrong");
  a_no_pin_use: assert property (s_sample_step and !pin_choice[1] and flex_r[3:2] != FLEX_FORCE_SATA
      |=> LANE_ROUTE_PCIE[1])
    else $error("lane not defaulted to pcie");
  a_pullup_flex: assert property (state_r inside {ST_SETTLE, ST_SAMPLE, ST_HOLD}
      |-> LANE_SELECT_PULLUP_EN[2] == (flex_r[5:4] == FLEX_PIN_SELECT))
    else $error("pull-up not tied to flex strap");
  a_lane_native: assert property (LANE_SELECT_NATIVE == LANE_NATIVE_RESET)
    else $error("select pin left native mode");
  a_lamp_gp: assert property (!$past(lamp_native_r) |-> !ACTIVITY_LAMP_OUT_OE)
    else $error("lamp driven in gp mode");
  a_sleep_gp: assert property (!$past(sleep_native_r[0]) |-> !DEVICE_SLEEP_OUT_OE[0])
    else $error("sleep pad driven in gp mode");
  a_settle_wait: assert property ($rose(state_r == ST_SETTLE) |-> (state_r == ST_SETTLE) [*8])
    else $error("pin sampled before pull-up settled");

  // capture side: pull-up held on until the straps are in, pcie until the pin is taken
  a_strap_pullup: assert property (state_r == ST_STRAP |-> LANE_SELECT_PULLUP_EN == PULLUP_RESET)
    else $error("pull-up off before strap capture");
  a_settle_count: assert property (state_r == ST_SETTLE |-> settle_cnt_r <= SETTLE_LAST)
    else $error("settle counter overran");
  a_pcie_before: assert property (!LANE_ASSIGN_DONE |-> &LANE_ROUTE_PCIE)
    else $error("lane left pcie before capture");
  a_forced_sata: assert property (s_sample_step and flex_r[1:0] == FLEX_FORCE_SATA
      |=> LANE_ROUTE_SATA[0])
    else $error("forced sata code ignored");

  // sideband pads: gp never drives, native takes effect one edge after its register
  a_sleep_native: assert property ($past(sleep_native_r[2]) |-> DEVICE_SLEEP_OUT_OE[2])
    else $error("sleep pad not driven in native mode");
  a_ilk_pcie: assert property (!route_sata_r[0] |=> INTERLOCK_TO_SATA[0])
    else $error("interlock passed on a pcie lane");
endmodule : combo_lane_select
